// ---- pkg/svss_params.svh ----
// register map, reset values and timing constants of the stop sequencer
`ifndef SVSS_PARAMS_SVH
`define SVSS_PARAMS_SVH

// ==========================================================
// register indexes (byte address is four times the index)
`define SVSS_IDX_SOFF_SEL 6'h01
`define SVSS_IDX_QS_SEL 6'h02
`define SVSS_IDX_OT_SEL 6'h03
`define SVSS_IDX_F1_SEL 6'h04
`define SVSS_IDX_F2_SEL 6'h05
`define SVSS_IDX_STOP_SPD 6'h08
`define SVSS_IDX_FAST_T 6'h09
`define SVSS_IDX_SLOW_T 6'h0b
`define SVSS_IDX_ETORQ 6'h0d
`define SVSS_IDX_BRK_DEEN 6'h11
`define SVSS_IDX_BRK_SPD 6'h12
`define SVSS_IDX_BRK_WAIT 6'h13
`define SVSS_IDX_BRK_OPEN 6'h14
`define SVSS_IDX_RELAY 6'h15
`define SVSS_IDX_STATUS 6'h20

// ==========================================================
// reset values
`define SVSS_RST_SOFF_SEL 16'h0000
`define SVSS_RST_QS_SEL 16'h0002
`define SVSS_RST_OT_SEL 16'h0001
`define SVSS_RST_F1_SEL 16'h0002
`define SVSS_RST_F2_SEL 16'h0001
`define SVSS_RST_STOP_SPD 16'h000a
`define SVSS_RST_FAST_T 32'h0000_0000
`define SVSS_RST_SLOW_T 32'h0000_0064
`define SVSS_RST_ETORQ 16'h03e8
`define SVSS_RST_BRK_DEEN 16'h0064
`define SVSS_RST_BRK_SPD 16'h001e
`define SVSS_RST_BRK_WAIT 16'h0064
`define SVSS_RST_BRK_OPEN 16'h0064
`define SVSS_RST_RELAY 16'h0014

// ==========================================================
// timing and limits
`define SVSS_CLK_PERIOD_NS 25
`define SVSS_MS_NS 1000000
`define SVSS_MS_CYCLES (`SVSS_MS_NS / `SVSS_CLK_PERIOD_NS)
`define SVSS_TORQ_FULL 16'h0bb8
`define SVSS_MS_CNT_MAX 18'h3ffff

`endif

// ---- pkg/svss_pkg.sv ----
// types of the stop sequencer
package svss_pkg;

	// ==========================================================
	// stop methods, end states and sequencer states
	typedef enum logic [2:0] {
		SVSS_M_COAST,
		SVSS_M_RAMP_FAST,
		SVSS_M_RAMP_SLOW,
		SVSS_M_ZERO,
		SVSS_M_ETORQ,
		SVSS_M_DBRAKE,
		SVSS_M_NONE
	} svss_method_e;

	typedef enum logic [1:0] {
		SVSS_H_DEEN,
		SVSS_H_LOCK,
		SVSS_H_DBRAKE
	} svss_hold_e;

	typedef enum logic [1:0] {
		SVSS_ST_START,
		SVSS_ST_RUN,
		SVSS_ST_STOP,
		SVSS_ST_HOLD
	} svss_state_e;

	typedef struct packed {
		svss_method_e method;
		svss_hold_e hold;
	} svss_mode_s;

endpackage

// ---- hdl/svss_ramp.sv ----
// linear speed ramp from a captured speed down to zero
`timescale 1ns/10ps
module svss_ramp (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire logic signed [15:0] speed_i,
	input wire logic [31:0] time_ms_i,
	input wire logic tick_i,
	output logic signed [15:0] ref_o,
	output logic done_o
);

	logic [15:0] mag_ff;
	logic [15:0] start_mag_ff;
	logic neg_ff;
	logic [47:0] acc_ff;
	logic [47:0] nxt_acc;
	logic dec;

	// ==========================================================
	// each ms the start speed is added, each step down costs the ramp time
	always_comb begin
		dec = (acc_ff >= {16'h0000, time_ms_i}) && (mag_ff != 16'h0000);
		nxt_acc = acc_ff;
		if (tick_i) begin
			nxt_acc = nxt_acc + {32'h0000_0000, start_mag_ff};
		end
		if (dec) begin
			nxt_acc = nxt_acc - {16'h0000, time_ms_i};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mag_ff <= 16'h0000;
			start_mag_ff <= 16'h0000;
			neg_ff <= 1'b0;
			acc_ff <= 48'h0;
		end else if (start_i) begin
			mag_ff <= (time_ms_i == 32'h0) ? 16'h0000 :
				(speed_i[15] ? 16'(-speed_i) : speed_i);
			start_mag_ff <= speed_i[15] ? 16'(-speed_i) : speed_i;
			neg_ff <= speed_i[15];
			acc_ff <= 48'h0;
		end else begin
			acc_ff <= nxt_acc;
			if (dec) begin
				mag_ff <= mag_ff - 16'h0001;
			end
		end
	end

	assign ref_o = neg_ff ? 16'(-mag_ff) : mag_ff;
	assign done_o = (mag_ff == 16'h0000);

endmodule // svss_ramp

// ---- hdl/svss_sequencer.sv ----
// stop mode sequencer with wishbone register file
// Behaviour
// - servo-enable removal: selector -4..2, negatives end in dynamic-brake hold
// - quick stop: selector 0..7, codes 5-7 end with position locked
// - overtravel: selector 0..7, default 1, code 7 ignores overtravel
// - class-1 fault: selector 0..2, coast or dynamic brake, default 2
// - class-2 fault: selector -5..3, negatives end in dynamic-brake hold
// - brake closes below programmable speed when servo disabled while turning
`timescale 1ns/10ps
`include "svss_params.svh"
module svss_sequencer #(
	parameter int MS_CYCLES = `SVSS_MS_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic servo_en_i,
	input wire logic quick_stop_i,
	input wire logic overtravel_i,
	input wire logic fault1_i,
	input wire logic fault2_i,
	input wire logic signed [15:0] speed_fb_i,
	input wire logic signed [15:0] speed_cmd_i,
	output logic signed [15:0] speed_ref_o,
	output logic [15:0] torque_limit_o,
	output logic power_en_o,
	output logic pos_lock_o,
	output logic dynamic_brake_o,
	output logic brake_release_o,
	output logic stopping_o
);

	// ==========================================================
	// registers
	logic [15:0] soff_sel_ff, qs_sel_ff, ot_sel_ff, f1_sel_ff, f2_sel_ff;
	logic [15:0] stop_spd_ff, etorq_ff, brk_deen_ff, brk_spd_ff, brk_wait_ff;
	logic [15:0] brk_open_ff, relay_ff;
	logic [31:0] fast_t_ff, slow_t_ff;
	logic ack_ff;
	logic [31:0] dat_ff;
	logic [31:0] wmask;
	logic [5:0] idx;
	logic wr;
	logic at_stop;
	svss_pkg::svss_state_e state_ff;
	svss_pkg::svss_mode_s mode_ff;
	logic [2:0] pri_ff;
	logic [17:0] ms_ff;
	logic [17:0] wait_ff;
	logic [31:0] prescale_ff;
	logic tick;
	logic ramp_start;
	logic signed [15:0] ramp_ref;
	logic ramp_done;
	logic [31:0] ramp_time;
	logic [15:0] spd_mag;
	logic [2:0] cause_pri;
	svss_pkg::svss_mode_s cause_mode;
	logic brake_closed_ff;

	assign idx = adr_i[7:2];
	assign wr = cyc_i && stb_i && we_i && !ack_ff;
	assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
	assign at_stop = (state_ff == svss_pkg::SVSS_ST_HOLD);

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [31:0] m);
		merge = (old & ~m) | (d & m);
	endfunction

	// ==========================================================
	// wishbone slave: ack one cycle after request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= cyc_i && stb_i && !ack_ff;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_ff <= 32'h0000_0000;
		end else if (cyc_i && stb_i && !ack_ff) begin
			unique case (idx)
				`SVSS_IDX_SOFF_SEL: dat_ff <= {16'h0000, soff_sel_ff};
				`SVSS_IDX_QS_SEL: dat_ff <= {16'h0000, qs_sel_ff};
				`SVSS_IDX_OT_SEL: dat_ff <= {16'h0000, ot_sel_ff};
				`SVSS_IDX_F1_SEL: dat_ff <= {16'h0000, f1_sel_ff};
				`SVSS_IDX_F2_SEL: dat_ff <= {16'h0000, f2_sel_ff};
				`SVSS_IDX_STOP_SPD: dat_ff <= {16'h0000, stop_spd_ff};
				`SVSS_IDX_FAST_T: dat_ff <= fast_t_ff;
				`SVSS_IDX_SLOW_T: dat_ff <= slow_t_ff;
				`SVSS_IDX_ETORQ: dat_ff <= {16'h0000, etorq_ff};
				`SVSS_IDX_BRK_DEEN: dat_ff <= {16'h0000, brk_deen_ff};
				`SVSS_IDX_BRK_SPD: dat_ff <= {16'h0000, brk_spd_ff};
				`SVSS_IDX_BRK_WAIT: dat_ff <= {16'h0000, brk_wait_ff};
				`SVSS_IDX_BRK_OPEN: dat_ff <= {16'h0000, brk_open_ff};
				`SVSS_IDX_RELAY: dat_ff <= {16'h0000, relay_ff};
				`SVSS_IDX_STATUS: dat_ff <= {17'h0, brake_closed_ff, dynamic_brake_o,
					power_en_o, pos_lock_o, pri_ff, mode_ff.hold, mode_ff.method, 1'b0, state_ff};
				default: dat_ff <= 32'h0000_0000;
			endcase
		end
	end

	assign ack_o = ack_ff;
	assign dat_o = dat_ff;

	// selector and start-up timing words only change while stopped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			soff_sel_ff <= `SVSS_RST_SOFF_SEL;
			qs_sel_ff <= `SVSS_RST_QS_SEL;
			ot_sel_ff <= `SVSS_RST_OT_SEL;
			f1_sel_ff <= `SVSS_RST_F1_SEL;
			f2_sel_ff <= `SVSS_RST_F2_SEL;
			stop_spd_ff <= `SVSS_RST_STOP_SPD;
			fast_t_ff <= `SVSS_RST_FAST_T;
			slow_t_ff <= `SVSS_RST_SLOW_T;
			etorq_ff <= `SVSS_RST_ETORQ;
			brk_deen_ff <= `SVSS_RST_BRK_DEEN;
			brk_spd_ff <= `SVSS_RST_BRK_SPD;
			brk_wait_ff <= `SVSS_RST_BRK_WAIT;
			brk_open_ff <= `SVSS_RST_BRK_OPEN;
			relay_ff <= `SVSS_RST_RELAY;
		end else if (wr) begin
			unique case (idx)
				`SVSS_IDX_SOFF_SEL: if (at_stop) soff_sel_ff <= 16'(merge({16'h0, soff_sel_ff}, dat_i, wmask));
				`SVSS_IDX_QS_SEL: if (at_stop) qs_sel_ff <= 16'(merge({16'h0, qs_sel_ff}, dat_i, wmask));
				`SVSS_IDX_OT_SEL: if (at_stop) ot_sel_ff <= 16'(merge({16'h0, ot_sel_ff}, dat_i, wmask));
				`SVSS_IDX_F1_SEL: if (at_stop) f1_sel_ff <= 16'(merge({16'h0, f1_sel_ff}, dat_i, wmask));
				`SVSS_IDX_F2_SEL: if (at_stop) f2_sel_ff <= 16'(merge({16'h0, f2_sel_ff}, dat_i, wmask));
				`SVSS_IDX_STOP_SPD: stop_spd_ff <= 16'(merge({16'h0, stop_spd_ff}, dat_i, wmask));
				`SVSS_IDX_FAST_T: fast_t_ff <= merge(fast_t_ff, dat_i, wmask);
				`SVSS_IDX_SLOW_T: slow_t_ff <= merge(slow_t_ff, dat_i, wmask);
				`SVSS_IDX_ETORQ: etorq_ff <= 16'(merge({16'h0, etorq_ff}, dat_i, wmask));
				`SVSS_IDX_BRK_DEEN: brk_deen_ff <= 16'(merge({16'h0, brk_deen_ff}, dat_i, wmask));
				`SVSS_IDX_BRK_SPD: brk_spd_ff <= 16'(merge({16'h0, brk_spd_ff}, dat_i, wmask));
				`SVSS_IDX_BRK_WAIT: brk_wait_ff <= 16'(merge({16'h0, brk_wait_ff}, dat_i, wmask));
				`SVSS_IDX_BRK_OPEN: if (at_stop) brk_open_ff <= 16'(merge({16'h0, brk_open_ff}, dat_i, wmask));
				`SVSS_IDX_RELAY: if (at_stop) relay_ff <= 16'(merge({16'h0, relay_ff}, dat_i, wmask));
				default: ;
			endcase
		end
	end

	// ==========================================================
	// selector decoding
	function automatic svss_pkg::svss_mode_s mk(input svss_pkg::svss_method_e m,
		input svss_pkg::svss_hold_e h);
		mk.method = m;
		mk.hold = h;
	endfunction

	always_comb begin
		cause_pri = 3'h0;
		cause_mode = mk(svss_pkg::SVSS_M_COAST, svss_pkg::SVSS_H_DEEN);
		if (fault1_i) begin
			cause_pri = 3'h5;
			unique case (f1_sel_ff[3:0])
				4'h1: cause_mode = mk(svss_pkg::SVSS_M_DBRAKE, svss_pkg::SVSS_H_DEEN);
				4'h2: cause_mode = mk(svss_pkg::SVSS_M_DBRAKE, svss_pkg::SVSS_H_DBRAKE);
				default: cause_mode = mk(svss_pkg::SVSS_M_COAST, svss_pkg::SVSS_H_DEEN);
			endcase
		end else if (fault2_i) begin
			cause_pri = 3'h4;
			unique case (f2_sel_ff[3:0])
				4'hb: cause_mode = mk(svss_pkg::SVSS_M_ZERO, svss_pkg::SVSS_H_DBRAKE);
				4'hc: cause_mode = mk(svss_pkg::SVSS_M_ETORQ, svss_pkg::SVSS_H_DBRAKE);
				4'hd: cause_mode = mk(svss_pkg::SVSS_M_RAMP_FAST, svss_pkg::SVSS_H_DBRAKE);
				4'he: cause_mode = mk(svss_pkg::SVSS_M_RAMP_SLOW, svss_pkg::SVSS_H_DBRAKE);
				4'hf: cause_mode = mk(svss_pkg::SVSS_M_DBRAKE, svss_pkg::SVSS_H_DBRAKE);
				4'h1, 4'h2: cause_mode = mk(svss_pkg::SVSS_M_RAMP_SLOW, svss_pkg::SVSS_H_DEEN);
				4'h3: cause_mode = mk(svss_pkg::SVSS_M_ETORQ, svss_pkg::SVSS_H_DEEN);
				default: cause_mode = mk(svss_pkg::SVSS_M_COAST, svss_pkg::SVSS_H_DEEN);
			endcase
		end else if (overtravel_i && ot_sel_ff[3:0] != 4'h7) begin
			cause_pri = 3'h3;
			unique case (ot_sel_ff[3:0])
				4'h1: cause_mode = mk(svss_pkg::SVSS_M_ZERO, svss_pkg::SVSS_H_LOCK);
				4'h2: cause_mode = mk(svss_pkg::SVSS_M_ZERO, svss_pkg::SVSS_H_DEEN);
				4'h3: cause_mode = mk(svss_pkg::SVSS_M_RAMP_FAST, svss_pkg::SVSS_H_DEEN);
				4'h4: cause_mode = mk(svss_pkg::SVSS_M_RAMP_FAST, svss_pkg::SVSS_H_LOCK);
				4'h5: cause_mode = mk(svss_pkg::SVSS_M_DBRAKE, svss_pkg::SVSS_H_DEEN);
				4'h6: cause_mode = mk(svss_pkg::SVSS_M_DBRAKE, svss_pkg::SVSS_H_DBRAKE);
				default: cause_mode = mk(svss_pkg::SVSS_M_COAST, svss_pkg::SVSS_H_DEEN);
			endcase
		end else if (quick_stop_i) begin
			cause_pri = 3'h2;
			unique case (qs_sel_ff[3:0])
				4'h1: cause_mode = mk(svss_pkg::SVSS_M_RAMP_SLOW, svss_pkg::SVSS_H_DEEN);
				4'h2: cause_mode = mk(svss_pkg::SVSS_M_RAMP_FAST, svss_pkg::SVSS_H_DEEN);
				4'h3: cause_mode = mk(svss_pkg::SVSS_M_ETORQ, svss_pkg::SVSS_H_DEEN);
				4'h4: cause_mode = mk(svss_pkg::SVSS_M_ZERO, svss_pkg::SVSS_H_DEEN);
				4'h5: cause_mode = mk(svss_pkg::SVSS_M_RAMP_SLOW, svss_pkg::SVSS_H_LOCK);
				4'h6: cause_mode = mk(svss_pkg::SVSS_M_RAMP_FAST, svss_pkg::SVSS_H_LOCK);
				4'h7: cause_mode = mk(svss_pkg::SVSS_M_ETORQ, svss_pkg::SVSS_H_LOCK);
				default: cause_mode = mk(svss_pkg::SVSS_M_COAST, svss_pkg::SVSS_H_DEEN);
			endcase
		end else if (!servo_en_i) begin
			cause_pri = 3'h1;
			unique case (soff_sel_ff[3:0])
				4'hc: cause_mode = mk(svss_pkg::SVSS_M_RAMP_FAST, svss_pkg::SVSS_H_DBRAKE);
				4'hd: cause_mode = mk(svss_pkg::SVSS_M_ZERO, svss_pkg::SVSS_H_DBRAKE);
				4'he: cause_mode = mk(svss_pkg::SVSS_M_RAMP_SLOW, svss_pkg::SVSS_H_DBRAKE);
				4'hf: cause_mode = mk(svss_pkg::SVSS_M_DBRAKE, svss_pkg::SVSS_H_DBRAKE);
				4'h1: cause_mode = mk(svss_pkg::SVSS_M_RAMP_SLOW, svss_pkg::SVSS_H_DEEN);
				4'h2: cause_mode = mk(svss_pkg::SVSS_M_ZERO, svss_pkg::SVSS_H_DEEN);
				default: cause_mode = mk(svss_pkg::SVSS_M_COAST, svss_pkg::SVSS_H_DEEN);
			endcase
		end
	end

	// ==========================================================
	// ms tick and elapsed-time counters
	assign tick = (prescale_ff == 32'(MS_CYCLES - 1));
	assign spd_mag = speed_fb_i[15] ? 16'(-speed_fb_i) : speed_fb_i;

	always_ff @(posedge clk_i) begin
		if (rst_i || tick) begin
			prescale_ff <= 32'h0000_0000;
		end else begin
			prescale_ff <= prescale_ff + 32'h0000_0001;
		end
	end

	// ==========================================================
	// sequencer
	assign ramp_start = (state_ff != svss_pkg::SVSS_ST_STOP || cause_pri > pri_ff)
		&& cause_pri != 3'h0 && cause_pri >= pri_ff && state_ff != svss_pkg::SVSS_ST_HOLD;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_ff <= svss_pkg::SVSS_ST_HOLD;
			mode_ff <= mk(svss_pkg::SVSS_M_COAST, svss_pkg::SVSS_H_DEEN);
			pri_ff <= 3'h0;
			ms_ff <= `SVSS_MS_CNT_MAX;
			wait_ff <= 18'h0;
		end else begin
			if (tick && ms_ff != `SVSS_MS_CNT_MAX) begin
				ms_ff <= ms_ff + 18'h1;
			end
			if (tick && wait_ff != `SVSS_MS_CNT_MAX) begin
				wait_ff <= wait_ff + 18'h1;
			end
			unique case (state_ff)
				svss_pkg::SVSS_ST_HOLD: if (cause_pri == 3'h0) begin
					state_ff <= svss_pkg::SVSS_ST_START;
					pri_ff <= 3'h0;
					ms_ff <= 18'h0;
				end
				svss_pkg::SVSS_ST_START, svss_pkg::SVSS_ST_RUN, svss_pkg::SVSS_ST_STOP: begin
					if (ramp_start) begin
						state_ff <= svss_pkg::SVSS_ST_STOP;
						mode_ff <= cause_mode;
						pri_ff <= cause_pri;
						wait_ff <= 18'h0;
					end else if (state_ff == svss_pkg::SVSS_ST_STOP) begin
						if (spd_mag < stop_spd_ff && ramp_done) begin
							state_ff <= svss_pkg::SVSS_ST_HOLD;
							ms_ff <= 18'h0;
						end
					end else if (state_ff == svss_pkg::SVSS_ST_START &&
						ms_ff >= 18'(relay_ff) + 18'(brk_open_ff)) begin
						state_ff <= svss_pkg::SVSS_ST_RUN;
						pri_ff <= 3'h0;
					end
				end
				default: state_ff <= svss_pkg::SVSS_ST_HOLD;
			endcase
		end
	end

	// ramp time follows the latched method once the stop runs
	assign ramp_time = ((ramp_start ? cause_mode.method : mode_ff.method) ==
		svss_pkg::SVSS_M_RAMP_FAST) ? fast_t_ff : slow_t_ff;

	svss_ramp u_ramp (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(ramp_start),
		.speed_i(speed_fb_i),
		.time_ms_i(ramp_time),
		.tick_i(tick),
		.ref_o(ramp_ref),
		.done_o(ramp_done)
	);

	// holding brake closes below speed or after the wait limit
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			brake_closed_ff <= 1'b1;
		end else if (state_ff == svss_pkg::SVSS_ST_START) begin
			brake_closed_ff <= 1'b0;
		end else if (state_ff == svss_pkg::SVSS_ST_STOP && (spd_mag < brk_spd_ff ||
			wait_ff >= 18'(brk_wait_ff))) begin
			brake_closed_ff <= 1'b1;
		end else if (state_ff == svss_pkg::SVSS_ST_HOLD) begin
			brake_closed_ff <= 1'b1;
		end
	end

	// ==========================================================
	// drive outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			speed_ref_o <= 16'sh0000;
			torque_limit_o <= `SVSS_TORQ_FULL;
			power_en_o <= 1'b0;
			pos_lock_o <= 1'b0;
			dynamic_brake_o <= 1'b0;
			stopping_o <= 1'b0;
		end else begin
			speed_ref_o <= 16'sh0000;
			torque_limit_o <= `SVSS_TORQ_FULL;
			pos_lock_o <= 1'b0;
			stopping_o <= (state_ff == svss_pkg::SVSS_ST_STOP);
			unique case (state_ff)
				svss_pkg::SVSS_ST_START: begin
					dynamic_brake_o <= 1'b0;
					power_en_o <= (ms_ff >= 18'(relay_ff));
				end
				svss_pkg::SVSS_ST_RUN: begin
					speed_ref_o <= speed_cmd_i;
					power_en_o <= 1'b1;
				end
				svss_pkg::SVSS_ST_STOP: begin
					power_en_o <= !(mode_ff.method inside {svss_pkg::SVSS_M_COAST,
						svss_pkg::SVSS_M_DBRAKE});
					dynamic_brake_o <= (mode_ff.method == svss_pkg::SVSS_M_DBRAKE);
					if (mode_ff.method inside {svss_pkg::SVSS_M_RAMP_FAST,
						svss_pkg::SVSS_M_RAMP_SLOW}) begin
						speed_ref_o <= ramp_ref;
					end
					if (mode_ff.method == svss_pkg::SVSS_M_ETORQ) begin
						torque_limit_o <= etorq_ff;
					end
				end
				svss_pkg::SVSS_ST_HOLD: begin
					unique case (mode_ff.hold)
						svss_pkg::SVSS_H_LOCK: begin
							power_en_o <= 1'b1;
							pos_lock_o <= 1'b1;
							dynamic_brake_o <= 1'b0;
						end
						svss_pkg::SVSS_H_DBRAKE: begin
							power_en_o <= 1'b0;
							dynamic_brake_o <= 1'b1;
						end
						default: begin
							power_en_o <= power_en_o && (ms_ff < 18'(brk_deen_ff));
							dynamic_brake_o <= 1'b0;
						end
					endcase
				end
				default: power_en_o <= 1'b0;
			endcase
		end
	end

	assign brake_release_o = !brake_closed_ff;

endmodule // svss_sequencer

// ---- test/svss_motor_model.sv ----
// behavioural motor with power stage, holding brake and dynamic-brake relay
`timescale 1ns/10ps
module svss_motor_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic signed [15:0] speed_ref_i,
	input wire logic power_en_i,
	input wire logic dynamic_brake_i,
	input wire logic brake_release_i,
	output logic signed [15:0] speed_fb_o
);
	// ==========================================================
	// speed moves toward a target by a bounded step each cycle
	function automatic logic signed [15:0] toward(input logic signed [15:0] v,
		input logic signed [15:0] t, input logic signed [15:0] s);
		if (v > t + s) return v - s;
		if (v < t - s) return v + s;
		return t;
	endfunction

	// ==========================================================
	// driven: follows reference; unpowered: drag set by brakes
	always_ff @(posedge clk_i) begin
		if (rst_i) speed_fb_o <= 16'sh0;
		else if (power_en_i) speed_fb_o <= toward(speed_fb_o, speed_ref_i, 16'sh28);
		else if (dynamic_brake_i) speed_fb_o <= toward(speed_fb_o, 16'sh0, 16'sh1e);
		else if (!brake_release_i) speed_fb_o <= toward(speed_fb_o, 16'sh0, 16'sh14);
		else speed_fb_o <= toward(speed_fb_o, 16'sh0, 16'sh5);
	end
endmodule // svss_motor_model

// ---- test/svss_checker_assertions.sv ----
// port checker of the stop sequencer
`timescale 1ns/10ps
module svss_checker #(
	parameter int BRK_SPD = 30
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic servo_en_i,
	input wire logic quick_stop_i,
	input wire logic overtravel_i,
	input wire logic fault1_i,
	input wire logic fault2_i,
	input wire logic signed [15:0] speed_fb_i,
	input wire logic signed [15:0] speed_ref_o,
	input wire logic [15:0] torque_limit_o,
	input wire logic dynamic_brake_o,
	input wire logic brake_release_o,
	input wire logic stopping_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// ==========================================================
	// cycles since the stop causes last changed
	logic [4:0] cause_ff;
	logic [2:0] calm_ff;
	always_ff @(posedge clk_i) begin
		cause_ff <= {servo_en_i, quick_stop_i, overtravel_i, fault1_i, fault2_i};
	end
	always_ff @(posedge clk_i) begin
		if (rst_i || cause_ff != {servo_en_i, quick_stop_i, overtravel_i, fault1_i, fault2_i})
			calm_ff <= 3'h0;
		else if (calm_ff != 3'h7) calm_ff <= calm_ff + 3'h1;
	end

	function automatic logic [15:0] mag(input logic signed [15:0] v);
		return (v < 0) ? 16'(-v) : 16'(v);
	endfunction

	// ==========================================================
	// sequences and assertions
	sequence s_req;
		cyc_i && stb_i && !ack_o;
	endsequence
	sequence s_slow;
		stopping_o && (mag(speed_fb_i) < BRK_SPD);
	endsequence

	a_ack_next: assert property (s_req |=> ack_o)
		else $error("no ack one cycle after request");
	a_ack_single: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	a_unmapped_zero: assert property ((s_req ##0 (!we_i && adr_i[7:2] == 6'h3e)) |=> dat_o == 32'h0)
		else $error("unmapped read not zero");
	a_ramp_down: assert property (
		stopping_o && $past(stopping_o) && calm_ff >= 3'h4
		|-> mag(speed_ref_o) <= mag($past(speed_ref_o)))
		else $error("stop reference rose");
	a_brake_slow: assert property (s_slow ##1 s_slow |=> !brake_release_o)
		else $error("brake open below closing speed");
	a_run_torque: assert property (brake_release_o && !stopping_o |-> torque_limit_o == 16'h0bb8)
		else $error("torque limit not full while running");
	a_run_no_db: assert property (brake_release_o && !stopping_o |-> !dynamic_brake_o)
		else $error("dynamic brake on while running");
	a_fault_stop: assert property (
		$rose(fault1_i) && brake_release_o && !stopping_o
		|-> ##[1:3] (stopping_o || !brake_release_o))
		else $error("fault did not start a stop");
endmodule // svss_checker

bind svss_sequencer svss_checker #(.BRK_SPD(30)) u_svss_checker (
	.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
	.dat_o(dat_o), .ack_o(ack_o), .servo_en_i(servo_en_i), .quick_stop_i(quick_stop_i),
	.overtravel_i(overtravel_i), .fault1_i(fault1_i), .fault2_i(fault2_i),
	.speed_fb_i(speed_fb_i), .speed_ref_o(speed_ref_o), .torque_limit_o(torque_limit_o),
	.dynamic_brake_o(dynamic_brake_o), .brake_release_o(brake_release_o),
	.stopping_o(stopping_o));

// ---- test/tb.sv ----
// self-checking testbench of the stop sequencer
`timescale 1ns/10ps
`include "svss_params.svh"
module tb;
	logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, servo_en_i, quick_stop_i, overtravel_i;
	logic fault1_i, fault2_i, power_en_o, pos_lock_o, dynamic_brake_o, brake_release_o, stopping_o;
	logic [7:0] adr_i;
	logic [3:0] sel_i;
	logic [31:0] dat_i, dat_o, rd, w;
	logic signed [15:0] speed_fb_i, speed_cmd_i, speed_ref_o;
	logic [15:0] torque_limit_o;
	logic [7:0] e;
	logic [7:0] tbl [5][9];
	logic [31:0] rrst [14];
	logic [31:0] rfin [14];
	logic [5:0] ridx [14];
	int lo [5] = '{-4, 0, 0, 0, -5};
	int num [5] = '{7, 8, 8, 3, 9};
	int fails, n_checks, c, k, i;

	svss_sequencer #(.MS_CYCLES(10)) u_svss_sequencer (.clk_i(clk_i), .rst_i(rst_i),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
		.dat_o(dat_o), .ack_o(ack_o), .servo_en_i(servo_en_i), .quick_stop_i(quick_stop_i),
		.overtravel_i(overtravel_i), .fault1_i(fault1_i), .fault2_i(fault2_i),
		.speed_fb_i(speed_fb_i), .speed_cmd_i(speed_cmd_i), .speed_ref_o(speed_ref_o),
		.torque_limit_o(torque_limit_o), .power_en_o(power_en_o), .pos_lock_o(pos_lock_o),
		.dynamic_brake_o(dynamic_brake_o), .brake_release_o(brake_release_o),
		.stopping_o(stopping_o));
	svss_motor_model u_svss_motor_model (.clk_i(clk_i), .rst_i(rst_i), .speed_ref_i(speed_ref_o),
		.power_en_i(power_en_o), .dynamic_brake_i(dynamic_brake_o),
		.brake_release_i(brake_release_o), .speed_fb_o(speed_fb_i));

	// ==========================================================
	// clock, verdict, compare and bus tasks
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	task close_out;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task bus(input logic wr, input logic [5:0] idx, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= wr; adr_i <= {idx, 2'b00}; dat_i <= d; sel_i <= 4'hf;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		q = dat_o;
		cyc_i <= 1'b0; stb_i <= 1'b0;
		if (ack_o !== 1'b1) begin
			fails++;
			$display("ERROR %0t bus ack ran out", $time);
			close_out;
		end
	endtask

	task wait_state(input logic [2:0] s);
		int n;
		n = 0;
		do begin
			bus(1'b0, `SVSS_IDX_STATUS, 32'h0, rd);
			n++;
		end while (rd[2:0] !== s && n < 3000);
		if (rd[2:0] !== s) begin
			fails++;
			$display("ERROR %0t state wait ran out", $time);
			close_out;
		end
	endtask

	task cause(input int cs, input logic on);
		case (cs)
			0: servo_en_i <= !on;
			1: quick_stop_i <= on;
			2: overtravel_i <= on;
			3: fault1_i <= on;
			default: fault2_i <= on;
		endcase
	endtask

	// method in upper nibble, end state in lower nibble
	function automatic logic [7:0] exp_mode(input int cs, input int code);
		return tbl[cs][code - lo[cs]];
	endfunction

	// ==========================================================
	// main sequence
	initial begin
		tbl = '{'{8'h12, 8'h32, 8'h22, 8'h52, 8'h00, 8'h20, 8'h30, 8'h00, 8'h00},
			'{8'h00, 8'h20, 8'h10, 8'h40, 8'h30, 8'h21, 8'h11, 8'h41, 8'h00},
			'{8'h00, 8'h31, 8'h30, 8'h10, 8'h11, 8'h50, 8'h52, 8'hff, 8'h00},
			'{8'h00, 8'h50, 8'h52, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00},
			'{8'h32, 8'h42, 8'h12, 8'h22, 8'h52, 8'h00, 8'h20, 8'h20, 8'h40}};
		ridx = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h08, 6'h09, 6'h0b, 6'h0d, 6'h11, 6'h12,
			6'h13, 6'h14, 6'h15};
		rrst = '{32'h0, 32'h2, 32'h1, 32'h2, 32'h1, 32'ha, 32'h0, 32'h64, 32'h3e8, 32'h64,
			32'h1e, 32'h64, 32'h64, 32'h14};
		rfin = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'ha, 32'h3, 32'h5, 32'h3e8, 32'h2,
			32'h1e, 32'h64, 32'h2, 32'h2};
		fails = 0; n_checks = 0;
		rst_i = 1'b1; cyc_i = 1'b0; stb_i = 1'b0; we_i = 1'b0; adr_i = 8'h0; sel_i = 4'h0;
		dat_i = 32'h0; servo_en_i = 1'b0; quick_stop_i = 1'b0; overtravel_i = 1'b0;
		fault1_i = 1'b0; fault2_i = 1'b0; speed_cmd_i = 16'sh0;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		void'($urandom(32'hd007));
		for (i = 0; i < 14; i++) begin
			bus(1'b0, ridx[i], 32'h0, rd);
			chk(rd, rrst[i]);
			w = $urandom & ((i == 6 || i == 7) ? 32'hffffffff : 32'h0000ffff);
			bus(1'b1, ridx[i], w, rd);
			bus(1'b0, ridx[i], 32'h0, rd);
			chk(rd, w);
			bus(1'b1, ridx[i], rfin[i], rd);
		end
		bus(1'b1, 6'h3e, $urandom, rd);
		bus(1'b0, 6'h3e, 32'h0, rd);
		chk(rd, 32'h0);
		for (c = 0; c < 5; c++) begin
			for (k = 0; k < num[c]; k++) begin
				e = exp_mode(c, lo[c] + k);
				bus(1'b1, ridx[c], 32'(lo[c] + k) & 32'h0000ffff, rd);
				servo_en_i <= 1'b1; quick_stop_i <= 1'b0; overtravel_i <= 1'b0;
				fault1_i <= 1'b0; fault2_i <= 1'b0;
				wait_state(3'h1);
				w = 32'hc8 + ($urandom % 32'h514);
				speed_cmd_i <= ($urandom % 2) ? 16'(w) : -16'(w);
				if (c == 1 && k == 0) begin
					bus(1'b1, ridx[1], 32'h5, rd);
					bus(1'b0, ridx[1], 32'h0, rd);
					chk(rd, 32'h0);
				end
				repeat (60) @(posedge clk_i);
				cause(c, 1'b1);
				if (e == 8'hff) begin
					repeat (40) @(posedge clk_i);
					bus(1'b0, `SVSS_IDX_STATUS, 32'h0, rd);
					chk({29'h0, rd[2:0]}, 32'h1);
					servo_en_i <= 1'b0;
					wait_state(3'h3);
				end else begin
					repeat (4) @(posedge clk_i);
					w = {16'h0001, (e[7:4] == 4'h4) ? rfin[8][15:0] : `SVSS_TORQ_FULL};
					chk({15'h0, stopping_o, torque_limit_o}, w);
					if (e[7:4] != 4'h1 && e[7:4] != 4'h2) chk({16'h0, speed_ref_o}, 32'h0);
					wait_state(3'h3);
					chk({25'h0, rd[5:3], 2'b00, rd[7:6]}, {24'h0, e});
					repeat (30) @(posedge clk_i);
					chk({31'h0, pos_lock_o}, {31'h0, e[3:0] == 4'h1});
					chk({31'h0, dynamic_brake_o}, {31'h0, e[3:0] == 4'h2});
					chk({31'h0, brake_release_o}, 32'h0);
					if (e[3:0] != 4'h2) chk({31'h0, power_en_o}, {31'h0, e[3:0] == 4'h1});
				end
			end
		end
		close_out;
	end
endmodule // tb
